/* rtl/carrier_pkg.sv */
// constants, register map and carrier tables for the carrier select block
package carrier_pkg;
	// system clock
	localparam int CLK_HZ        = 25_000_000;
	localparam int CLK_PERIOD_NS = 40;

	// register byte offsets
	localparam logic [7:0] ADDR_CFG  = 8'h00;
	localparam logic [7:0] ADDR_GAIN = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;

	// field positions
	localparam int CFG_SEL_LSB  = 0;
	localparam int CFG_SOFT_BIT = 4;
	localparam int CFG_AUTO_BIT = 5;
	localparam int CTRL_VIS_BIT = 0;
	localparam int CTRL_PWS_LSB = 1;

	// reset values
	localparam logic [3:0] SEL_RESET  = 4'h1;
	localparam logic       SOFT_RESET = 1'b1;
	localparam logic       AUTO_RESET = 1'b0;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic       VIS_RESET  = 1'b0;
	localparam logic [1:0] PWS_RESET  = 2'h0;

	// setting limits
	localparam logic [3:0] SOFT_MAX_SEL   = 4'h5;
	localparam logic [3:0] REDUCE_MIN_SEL = 4'h3;
	localparam logic [3:0] REDUCED_SEL    = 4'h2;
	localparam logic [7:0] GAIN_MAX       = 8'hc8;
	localparam int         GAIN_UNITY     = 100;
	localparam logic [7:0] LOAD_LIMIT_PCT = 8'h55;

	// time of sustained heavy load before the carrier drops
	localparam int HEAVY_TIME_MS = 100;
	localparam int HEAVY_CYCLES  = HEAVY_TIME_MS * (CLK_HZ / 1000);

	// soft-pwm dither: period varies by -64..+63 cycles
	localparam logic [15:0] JIT_OFFSET = 16'h0040;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// carrier frequency of a setting, in units of 0.1 kHz
	function automatic int freq_dhz(input int code);
		if (code == 0)
			return 7;
		else if (code == 15)
			return 145;
		else
			return code * 10;
	endfunction

	// carrier period in clock cycles for a setting
	function automatic int period_cycles(input int code);
		return CLK_HZ / (freq_dhz(code) * 100);
	endfunction
endpackage

/* rtl/carrier_if.sv */
// carrier selection and timing between control and divider
interface carrier_if;
	logic [3:0]  code;    // carrier setting in effect
	logic        soft_en; // dither the period
	logic        tick;    // last cycle of a carrier period
	logic [15:0] period;  // current period in cycles
	logic [15:0] count;   // position inside the period

	modport ctrl (output code, soft_en, input tick, period, count);
	modport gen  (input code, soft_en, output tick, period, count);
endinterface

/* rtl/carrier_divider.sv */
// programmable carrier period counter with optional dither
module carrier_divider
	import carrier_pkg::*;
	(
	input  logic mclk,   // system clock
	input  logic nrst,   // async reset, active low
	carrier_if.gen cif   // selection in, timing out
	);

	wire  [15:0] lut [16];
	logic [15:0] period;
	logic [15:0] count;
	logic [15:0] lfsr;

	// one period constant per setting, built at elaboration
	for (genvar i = 0; i < 16; i++) begin : g_lut
		assign lut[i] = 16'(period_cycles(i));
	end

	wire         wrap     = (count == period - 16'h0001);
	wire [15:0]  base     = lut[cif.code];
	wire         lfsr_fb  = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10];
	// dither around the nominal period, so the mean stays on frequency
	wire [15:0]  dithered = base - JIT_OFFSET + {9'h000, lfsr[6:0]};
	wire [15:0]  next_period = cif.soft_en ? dithered : base;

	assign cif.tick   = wrap;
	assign cif.period = period;
	assign cif.count  = count;

	// new period is loaded only on wrap: no truncated pwm cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			count  <= 16'h0000;
			period <= 16'(period_cycles(int'(SEL_RESET)));
			lfsr   <= 16'hace1;
		end else if (wrap) begin
			count  <= 16'h0000;
			period <= next_period;
			lfsr   <= {lfsr[14:0], lfsr_fb};
		end else begin
			count  <= count + 16'h0001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	table_load_a: assert property (wrap && !cif.soft_en |=>
		period == $past(base))
		else $error("period not taken from setting table");
	low_setting_a: assert property (wrap && !cif.soft_en &&
		cif.code == 4'h0 |=> period == 16'(period_cycles(0)))
		else $error("setting 0 period wrong");
	boundary_a: assert property ($changed(period) |->
		$past(wrap))
		else $error("period changed inside a carrier cycle");
	dither_c: cover property (wrap && cif.soft_en ##1
		period != $past(base));
endmodule

/* rtl/speed_smoother.sv */
// output frequency correction against resonance current ripple
module speed_smoother
	import carrier_pkg::*;
	(
	input  logic               mclk,     // system clock
	input  logic               nrst,     // async reset, active low
	input  logic               tick,     // carrier boundary
	input  logic [7:0]         gain,     // smoothing gain, percent
	input  logic signed [15:0] ripple,   // current fluctuation
	input  logic [15:0]        freq_ref, // commanded frequency
	output logic [15:0]        freq_out  // corrected frequency
	);

	// 100 percent gain subtracts the ripple one to one
	wire signed [24:0] prod = ripple * $signed({1'b0, gain});
	wire signed [24:0] corr = prod / 25'sd100;
	wire signed [25:0] sum  = $signed({10'h000, freq_ref}) -
		{corr[24], corr};
	// clamp into the unsigned output range
	wire [15:0] sat = sum[25] ? 16'h0000 :
		(|sum[24:16]) ? 16'hffff : sum[15:0];

	// one update per carrier period keeps the loop slow and quiet
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			freq_out <= 16'h0000;
		else if (tick)
			freq_out <= sat;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	no_gain_a: assert property (tick && gain == 8'h00 |=>
		freq_out == $past(freq_ref))
		else $error("zero gain changed the frequency");
	hold_between_a: assert property (!tick |=>
		$stable(freq_out))
		else $error("frequency moved off a carrier boundary");
endmodule

/* rtl/carrier_pwm_select_smoothing.sv */
// carrier selection, auto reduction and smoothing with axi4-lite registers
// What this block does
// - Carrier setting 0 to 15; 1 to 14 give that many kHz; default 1.
// - Setting 0 gives 0.7 kHz carrier, setting 15 gives 14.5 kHz.
// - Soft-pwm off when select is 0; when 1, active only for settings 0-5.
// - Auto reduction off (default): carrier follows the setting at any load.
// - Auto on, setting 3 or more, sustained 85% load: carrier drops to 2 kHz.
// - Carrier, soft, auto and gain writes accepted only while visibility is 0.
// - Carrier and soft settings writable while running, whatever write select.
// - Smoothing gain 0 to 200 percent, default 0, 100 is the reference.
// - Nonzero gain corrects output frequency against resonance current ripple.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
module carrier_pwm_select_smoothing
	import carrier_pkg::*;
	#(
	parameter int HEAVY_LOAD_CYCLES = HEAVY_CYCLES // heavy load filter
	)
	(
	input  logic        mclk,           // 25 mhz clock
	input  logic        nrst,           // async reset, active low
	input  logic [7:0]  awaddr,         // write address
	input  logic        awvalid,        // write address valid
	output logic        awready,        // write address ready
	input  logic [31:0] wdata,          // write data
	input  logic [3:0]  wstrb,          // write byte enables
	input  logic        wvalid,         // write data valid
	output logic        wready,         // write data ready
	output logic [1:0]  bresp,          // write response
	output logic        bvalid,         // write response valid
	input  logic        bready,         // write response ready
	input  logic [7:0]  araddr,         // read address
	input  logic        arvalid,        // read address valid
	output logic        arready,        // read address ready
	output logic [31:0] rdata,          // read data
	output logic [1:0]  rresp,          // read response
	output logic        rvalid,         // read data valid
	input  logic        rready,         // read data ready
	input  logic        drive_running,  // motor output active
	input  logic [7:0]  current_pct,    // output current, % of rated
	input  logic [15:0] current_ripple, // signed current fluctuation
	input  logic [15:0] freq_ref,       // commanded output frequency
	output logic [15:0] freq_out,       // smoothed output frequency
	output logic        carrier_tick,   // last cycle of carrier period
	output logic [15:0] carrier_count,  // carrier phase counter
	output logic [15:0] carrier_period, // carrier period in cycles
	output logic        soft_pwm_active, // dither in use
	output logic        carrier_reduced  // load reduction in force
	);

	// register decode used only by the read path, for its response
	function automatic logic reg_mapped(input logic [7:0] a);
		return a == ADDR_CFG || a == ADDR_GAIN ||
			a == ADDR_CTRL || a == ADDR_STAT;
	endfunction

	logic [3:0]  carrier_freq_select;
	logic        soft_pwm_select;
	logic        carrier_auto_reduce_select;
	logic [7:0]  speed_smoothing_gain;
	logic        extended_param_visibility;
	logic [1:0]  param_write_select;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic [21:0] heavy_cnt;

	carrier_if cif ();

	// write channel: address and data are caught in either order
	assign awready = !aw_held;
	assign wready  = !w_held;
	wire do_write  = aw_held && w_held && !bvalid;

	// write decode
	wire wr_cfg    = aw_addr_q == ADDR_CFG;
	wire wr_gain   = aw_addr_q == ADDR_GAIN;
	wire wr_ctrl   = aw_addr_q == ADDR_CTRL;
	wire ext_open  = extended_param_visibility == 1'b0;
	wire lane0     = w_strb_q[0];
	wire gain_ok   = w_data_q[7:0] <= GAIN_MAX;
	// gated settings refuse the write while visibility is set
	wire wr_legal  = wr_ctrl ||
		(wr_cfg && ext_open) ||
		(wr_gain && ext_open && (gain_ok || !lane0));
	wire commit    = do_write && wr_legal && lane0;

	// hold the two write channels until both are in
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (do_write) begin
				aw_held   <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (do_write) begin
				w_held   <= 1'b0;
			end
		end
	end

	// write response, one per address and data pair, refused writes included
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_legal ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// settings; no run or write-select gating on the carrier fields
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			carrier_freq_select        <= SEL_RESET;
			soft_pwm_select            <= SOFT_RESET;
			carrier_auto_reduce_select <= AUTO_RESET;
			speed_smoothing_gain       <= GAIN_RESET;
			extended_param_visibility  <= VIS_RESET;
			param_write_select         <= PWS_RESET;
		end else if (commit && wr_cfg) begin
			carrier_freq_select <=
				w_data_q[CFG_SEL_LSB +: 4];
			soft_pwm_select     <= w_data_q[CFG_SOFT_BIT];
			carrier_auto_reduce_select <=
				w_data_q[CFG_AUTO_BIT];
		end else if (commit && wr_gain) begin
			speed_smoothing_gain <= w_data_q[7:0];
		end else if (commit && wr_ctrl) begin
			extended_param_visibility <= w_data_q[CTRL_VIS_BIT];
			param_write_select <= w_data_q[CTRL_PWS_LSB +: 2];
		end
	end

	// heavy load must persist before the carrier is lowered
	wire heavy      = current_pct >= LOAD_LIMIT_PCT;
	wire reduce_arm = carrier_auto_reduce_select &&
		carrier_freq_select >= REDUCE_MIN_SEL && heavy;
	// gated by the arm, so clearing auto gives the setting back at once
	wire reduce_now = reduce_arm &&
		heavy_cnt == 22'(HEAVY_LOAD_CYCLES);

	// saturating filter; any dip below the limit restarts it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			heavy_cnt <= 22'h000000;
		else if (!reduce_arm)
			heavy_cnt <= 22'h000000;
		else if (!reduce_now)
			heavy_cnt <= heavy_cnt + 22'h000001;
	end

	// setting handed to the divider; its period is taken at the next carrier wrap
	wire [3:0] eff_code = reduce_now ? REDUCED_SEL :
		carrier_freq_select;
	wire soft_active = soft_pwm_select &&
		carrier_freq_select <= SOFT_MAX_SEL;

	assign cif.code        = eff_code;
	assign cif.soft_en     = soft_active;
	assign carrier_tick    = cif.tick;
	assign carrier_count   = cif.count;
	assign carrier_period  = cif.period;
	assign soft_pwm_active = soft_active;
	assign carrier_reduced = reduce_now;

	carrier_divider u_div (
		.mclk (mclk),
		.nrst (nrst),
		.cif  (cif)
	);

	speed_smoother u_smooth (
		.mclk     (mclk),
		.nrst     (nrst),
		.tick     (cif.tick),
		.gain     (speed_smoothing_gain),
		.ripple   ($signed(current_ripple)),
		.freq_ref (freq_ref),
		.freq_out (freq_out)
	);

	// read words; unused bits read as zero
	wire [31:0] cfg_word  = {26'h0, carrier_auto_reduce_select,
		soft_pwm_select, carrier_freq_select};
	wire [31:0] gain_word = {24'h0, speed_smoothing_gain};
	wire [31:0] ctrl_word = {29'h0, param_write_select,
		extended_param_visibility};
	wire [31:0] stat_word = {24'h0, drive_running, heavy,
		reduce_now, soft_active, eff_code};
	wire [31:0] rd_mux    =
		(araddr == ADDR_CFG)  ? cfg_word  :
		(araddr == ADDR_GAIN) ? gain_word :
		(araddr == ADDR_CTRL) ? ctrl_word :
		(araddr == ADDR_STAT) ? stat_word : 32'h0000_0000;

	// read channel: one read outstanding, answered the next cycle
	assign arready = !rvalid;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_mux;
			rresp  <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	setting_range_a: assert property (eff_code ==
		carrier_freq_select || eff_code == REDUCED_SEL)
		else $error("carrier code not from setting");
	soft_window_a: assert property (soft_pwm_active |->
		soft_pwm_select && carrier_freq_select <= 4'h5)
		else $error("soft pwm outside settings 0 to 5");
	fixed_carrier_a: assert property
		(!carrier_auto_reduce_select |-> eff_code ==
		carrier_freq_select && !carrier_reduced)
		else $error("carrier moved with reduction off");
	reduce_carrier_a: assert property (reduce_arm &&
		heavy_cnt == 22'(HEAVY_LOAD_CYCLES) - 22'h000001 ##1
		reduce_arm |-> eff_code == REDUCED_SEL)
		else $error("carrier not lowered after heavy load");
	light_release_a: assert property (!heavy |=>
		!carrier_reduced)
		else $error("reduction kept after load fell");
	gated_write_a: assert property (do_write && wr_cfg &&
		!ext_open |=> $stable(carrier_freq_select) &&
		bresp == RESP_SLVERR)
		else $error("setting written while hidden");
	run_write_a: assert property (do_write && wr_cfg &&
		ext_open && lane0 |=> carrier_freq_select ==
		$past(w_data_q[3:0]) && bresp == RESP_OKAY)
		else $error("carrier write refused");
	gain_limit_a: assert property (speed_smoothing_gain
		<= 8'hc8)
		else $error("gain above 200 percent");
	write_answer_a: assert property (do_write |=> bvalid)
		else $error("write not answered");

	// answers stand until taken, and refusals leave the settings alone
	bresp_hold_a: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp))
		else $error("write response dropped early");
	read_hold_a: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata))
		else $error("read data dropped early");
	ctrl_open_a: assert property (do_write && wr_ctrl |=>
		bresp == RESP_OKAY)
		else $error("control write refused");
	stat_refuse_a: assert property (do_write &&
		aw_addr_q == ADDR_STAT |=> bresp == RESP_SLVERR)
		else $error("status register accepted a write");
	gain_hidden_a: assert property (do_write && wr_gain &&
		!ext_open |=> $stable(speed_smoothing_gain) &&
		bresp == RESP_SLVERR)
		else $error("gain written while hidden");
	lane_skip_a: assert property (do_write && !lane0 |=>
		$stable(carrier_freq_select) &&
		$stable(speed_smoothing_gain))
		else $error("write without low lane changed a setting");
	gain_write_a: assert property (do_write && wr_gain &&
		ext_open && lane0 && gain_ok |=>
		speed_smoothing_gain == $past(w_data_q[7:0]))
		else $error("legal gain write lost");
	gain_refuse_a: assert property (do_write && wr_gain &&
		lane0 && !gain_ok |=> $stable(speed_smoothing_gain) &&
		bresp == RESP_SLVERR)
		else $error("gain above 200 percent taken");
	soft_select_a: assert property (soft_pwm_select &&
		carrier_freq_select <= SOFT_MAX_SEL |-> soft_pwm_active)
		else $error("soft pwm missing in its window");
	reduce_gate_a: assert property (!reduce_arm |->
		!carrier_reduced)
		else $error("reduction without its conditions");
	reduce_hold_a: assert property (carrier_reduced ##1
		reduce_arm |-> carrier_reduced)
		else $error("reduction dropped under load");

	reduce_c: cover property (reduce_arm ##1 carrier_reduced);
	soft_c: cover property (soft_pwm_active && carrier_tick);
	refused_c: cover property (bvalid && bresp == RESP_SLVERR);
	readback_c: cover property (do_write ##[1:8] rvalid);
endmodule

/* sim/motor_stage_model.sv */
// motor power stage model: load current and resonance ripple feedback
module motor_stage_model (
	input  wire logic        mclk,          // system clock
	input  wire logic        nrst,          // async reset, active low
	input  wire logic        carrier_tick,  // carrier boundary
	input  wire logic [7:0]  load_pct,      // load set by the bench
	output logic      [7:0]  current_pct,   // measured current, % rated
	output logic      [15:0] current_ripple // resonance ripple, signed
);
	timeunit 1ns;
	timeprecision 1ps;
	// current follows the load one cycle late, like a sensor path
	// ripple flips each carrier period, so both output clamps get used
	// no fast current limit here; the operator turns it off at low carrier
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			current_pct    <= 8'h00;
			current_ripple <= 16'h03e7;
		end else begin
			current_pct <= load_pct;
			if (carrier_tick)
				current_ripple <= current_ripple ^ 16'h8937;
		end
	end
endmodule

/* sim/test_carrier_pwm_select_smoothing.sv */
// self-checking bench for the carrier select and smoothing block
module test_carrier_pwm_select_smoothing import carrier_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0, nrst = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, load_pct = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, drive_running = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic [15:0] freq_ref = 16'h3000;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [15:0] freq_out, carrier_count, carrier_period, current_ripple;
	wire         carrier_tick, soft_pwm_active, carrier_reduced;
	wire  [7:0]  current_pct;
	int          n_errors = 0, check_count = 0;
	logic [7:0]  g = 8'h00;
	logic [1:0]  r;
	logic [31:0] d;
	logic [7:0]  gated [2] = '{ADDR_CFG, ADDR_GAIN};
	logic [7:0]  soft_cfg [6] = '{8'h15, 8'h16, 8'h10, 8'h05, 8'h1f, 8'h0f};
	logic        soft_exp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end

	always #20 mclk = ~mclk;

	// short heavy-load filter keeps the reduction test brief
	carrier_pwm_select_smoothing #(.HEAVY_LOAD_CYCLES(20)) DUT (
		.mclk(mclk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.drive_running(drive_running), .current_pct(current_pct),
		.current_ripple(current_ripple), .freq_ref(freq_ref),
		.freq_out(freq_out), .carrier_tick(carrier_tick),
		.carrier_count(carrier_count), .carrier_period(carrier_period),
		.soft_pwm_active(soft_pwm_active), .carrier_reduced(carrier_reduced)
	);

	motor_stage_model motor (
		.mclk(mclk), .nrst(nrst), .carrier_tick(carrier_tick),
		.load_pct(load_pct), .current_pct(current_pct),
		.current_ripple(current_ripple)
	);

	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// one write; each channel is released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= v;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		`CHK(bvalid, 1'b1)
		r = bresp;
		bready <= 1'b0;
		@(posedge mclk);
	endtask

	// one read; rready stays up until the data is seen
	task automatic rd(input logic [7:0] a);
		int n;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		`CHK(rvalid, 1'b1)
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge mclk);
	endtask

	// wait for a wrap, then check the new period and the smoothed output
	task automatic wait_tick(input int c);
		int n;
		int e;
		logic [15:0] p;
		logic [15:0] dev;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (carrier_tick !== 1'b1 && n < 40000);
		`CHK(carrier_count, carrier_period - 16'h0001)
		e = int'(freq_ref) - int'($signed(current_ripple)) * int'(g) / 100;
		e = (e < 0) ? 0 : (e > 65535) ? 65535 : e;
		p = 16'(25000000 / ((c == 0) ? 700 : (c == 15) ? 14500 : c * 1000));
		@(negedge mclk);
		dev = carrier_period - p + JIT_OFFSET;
		// a dithered period must stay inside the jitter band
		if (soft_pwm_active === 1'b1)
			`CHK(dev < 2 * JIT_OFFSET, 1'b1)
		else
			`CHK(carrier_period, p)
		`CHK(freq_out, 16'(e))
		@(posedge mclk);
	endtask

	// main sequence: reset values, gating, soft window, codes, reduction
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		rd(ADDR_CFG);
		`CHK(d[5:0], 6'h11)
		rd(ADDR_GAIN);
		`CHK(d[7:0], 8'h00)
		`CHK(carrier_period, 16'h61a8)
		rd(8'h10);
		`CHK({rresp, d}, {RESP_SLVERR, 32'h0})
		drive_running <= 1'b1;
		wr(ADDR_CTRL, 32'h1);
		foreach (gated[i]) begin
			wr(gated[i], 32'h05);
			`CHK(r, RESP_SLVERR)
		end
		rd(ADDR_CFG);
		`CHK(d[5:0], 6'h11)
		wr(ADDR_CTRL, 32'h6);
		rd(ADDR_CTRL);
		`CHK(d[2:0], 3'h6)
		foreach (soft_cfg[i]) begin
			wr(ADDR_CFG, {24'h0, soft_cfg[i]});
			`CHK(r, RESP_OKAY)
			`CHK(soft_pwm_active, soft_exp[i])
		end
		wait_tick(15);
		wr(ADDR_GAIN, 32'hc9);
		`CHK(r, RESP_SLVERR)
		wr(ADDR_GAIN, 32'hc8);
		g = 8'hc8;
		rd(ADDR_GAIN);
		`CHK(d[7:0], 8'hc8)
		wstrb <= 4'he;
		wr(ADDR_GAIN, 32'h10);
		`CHK(r, RESP_OKAY)
		wstrb <= 4'hf;
		rd(ADDR_GAIN);
		`CHK(d[7:0], 8'hc8)
		for (int c = 14; c >= 3; c--) begin
			wr(ADDR_CFG, (c == 5) ? 32'h15 : 32'(c));
			wait_tick(c);
		end
		// load at the threshold: no reduction until auto is selected
		load_pct <= 8'h55;
		repeat (40) @(posedge mclk);
		`CHK(carrier_reduced, 1'b0)
		wr(ADDR_CFG, 32'h23);
		repeat (10) @(posedge mclk);
		`CHK(carrier_reduced, 1'b0)
		repeat (20) @(posedge mclk);
		`CHK(carrier_reduced, 1'b1)
		rd(ADDR_STAT);
		`CHK(d[7:0], 8'he2)
		wait_tick(2);
		load_pct <= 8'h54;
		repeat (3) @(posedge mclk);
		`CHK(carrier_reduced, 1'b0)
		wr(ADDR_CFG, 32'h02);
		load_pct <= 8'h14;
		// low reference: a positive ripple reaches the zero output clamp
		freq_ref <= 16'h0100;
		wait_tick(2);
		wr(ADDR_CFG, 32'h00);
		wait_tick(0);
		summarize();
	end

	// cut a hang short; the full sequence needs about 96k cycles
	initial begin
		repeat (120000) @(posedge mclk);
		n_errors++;
		summarize();
	end
endmodule
